// ### src/sor_cfg.svh
`ifndef SOR_CFG_SVH
`define SOR_CFG_SVH

// Data path shape
`define SOR_SAMPLE_W 24
`define SOR_N_OUT 4
`define SOR_N_ASRC 4
`define SOR_N_SIN 8
`define SOR_FIFO_DEPTH 8
`define SOR_LVL_W 4

// Register indices, byte address is four times the index
`define SOR_IDX_ROUTE01 6'h13
`define SOR_IDX_ROUTE23 6'h14
`define SOR_IDX_CTRL 6'h20
`define SOR_IDX_STATUS 6'h21

// Reset values
`define SOR_RST_ROUTE01 8'h54
`define SOR_RST_ROUTE23 8'h76
`define SOR_RST_CTRL 8'h01

// Field positions
`define SOR_SEL_W 4
`define SOR_SEL_LO_POS 0
`define SOR_SEL_HI_POS 4
`define SOR_CTRL_EN_POS 0
`define SOR_STAT_RSVD_POS 0
`define SOR_STAT_EMPTY_POS 4
`define SOR_STAT_FULL_POS 5
`define SOR_STAT_LVL_POS 8

`endif

// ### src/sor_fifo.sv
`timescale 1ns/100ps
`include "sor_cfg.svh"
module sor_fifo import sor_pkg::*; #(
	parameter int W = `SOR_N_OUT*`SOR_SAMPLE_W,
	parameter int DEPTH = `SOR_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	sor_stream_if.snk wr,
	sor_stream_if.src rd,
	output sor_lvl_t level,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wp_reg;
	logic [AW-1:0] rp_reg;
	logic [AW:0] cnt_reg;
	logic [AW:0] cnt_next;
	logic [W-1:0] odata_reg;
	logic ovalid_reg;
	logic push;
	logic take;

	assign full = (cnt_reg == (AW+1)'(DEPTH));
	assign empty = (cnt_reg == '0);
	assign wr.ready = ~full;
	assign push = wr.valid & ~full;
	assign take = ~empty & (~ovalid_reg | rd.ready);
	assign cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(take);
	assign level = sor_lvl_t'(cnt_reg);
	assign rd.valid = ovalid_reg;
	assign rd.data = odata_reg;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_reg] <= wr.data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg <= '0;
			rp_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wp_reg <= push ? wp_reg + AW'(1) : wp_reg;
			rp_reg <= take ? rp_reg + AW'(1) : rp_reg;
			cnt_reg <= cnt_next;
		end
	end

	// Output word stays in a register until the sink takes it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			odata_reg <= '0;
			ovalid_reg <= 1'b0;
		end else if (take) begin
			odata_reg <= mem[rp_reg];
			ovalid_reg <= 1'b1;
		end else if (rd.ready) begin
			ovalid_reg <= 1'b0;
		end
	end
endmodule

// ### src/sor_mux.sv
`timescale 1ns/100ps
`include "sor_cfg.svh"
module sor_mux import sor_pkg::*; (
	input wire sor_sel_t sel,
	input wire logic [`SOR_N_ASRC*`SOR_SAMPLE_W-1:0] asrc_data,
	input wire logic [`SOR_N_SIN*`SOR_SAMPLE_W-1:0] sin_data,
	output sor_sample_t data,
	output logic rsvd
);
	sor_src_e kind;
	logic [1:0] asrc_idx;
	logic [2:0] sin_idx;
	sor_sample_t asrc_pick;
	sor_sample_t sin_pick;

	// Top bit picks serial inputs, next bit picks converter outputs
	assign kind = sel[3] ? SOR_SRC_SIN : (sel[2] ? SOR_SRC_ASRC : SOR_SRC_RSVD);
	assign asrc_idx = sel[1:0];
	assign sin_idx = sel[2:0];
	assign asrc_pick = asrc_data[asrc_idx*`SOR_SAMPLE_W +: `SOR_SAMPLE_W];
	assign sin_pick = sin_data[sin_idx*`SOR_SAMPLE_W +: `SOR_SAMPLE_W];
	// Reserved codes give silence and raise a flag
	assign data = (kind == SOR_SRC_SIN) ? sin_pick :
		(kind == SOR_SRC_ASRC) ? asrc_pick : '0;
	assign rsvd = (kind == SOR_SRC_RSVD);
endmodule

// ### src/sor_pkg.sv
`include "sor_cfg.svh"

package sor_pkg;
	typedef logic [`SOR_SAMPLE_W-1:0] sor_sample_t;
	typedef logic [`SOR_N_OUT*`SOR_SAMPLE_W-1:0] sor_word_t;
	typedef logic [`SOR_SEL_W-1:0] sor_sel_t;
	typedef logic [`SOR_LVL_W-1:0] sor_lvl_t;
	typedef enum logic [1:0] {
		SOR_SRC_RSVD = 2'b00,
		SOR_SRC_ASRC = 2'b01,
		SOR_SRC_SIN = 2'b10
	} sor_src_e;
endpackage

// ### src/sor_stream_if.sv
`timescale 1ns/100ps
interface sor_stream_if import sor_pkg::*; ();
	logic valid;
	logic ready;
	sor_word_t data;
	modport src(output valid, output data, input ready);
	modport snk(input valid, input data, output ready);
endinterface

// ### src/sor_top.sv
// Behaviour
// - Output channel 0 source is bits [3:0] of register 0x13, reset 0x4.
// - Output channel 1 source is bits [7:4] of register 0x13, reset 0x5.
// - Output channel 2 source is bits [3:0] of register 0x14, reset 0x6.
// - Output channel 3 source is bits [7:4] of register 0x14, reset 0x7.
// - Codes 0-3 reserved, 4-7 converter channels 0-3, 8-15 serial inputs 0-7.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/100ps
`include "sor_cfg.svh"
module sor_top import sor_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic src_valid,
	output logic src_ready,
	input wire logic [`SOR_N_ASRC*`SOR_SAMPLE_W-1:0] asrc_data,
	input wire logic [`SOR_N_SIN*`SOR_SAMPLE_W-1:0] sin_data,
	output logic out_valid,
	input wire logic out_ready,
	output sor_word_t out_data
);
	logic [7:0] serial_out_route_ch0_ch1_reg;
	logic [7:0] serial_out_route_ch2_ch3_reg;
	logic [7:0] ctrl_reg;
	logic [`SOR_N_OUT-1:0] rsvd_hit_reg;
	logic [`SOR_N_OUT-1:0] rsvd_hit_next;
	logic [31:0] prdata_reg;

	// Bus decode
	logic [5:0] idx;
	logic aligned;
	logic hit_route01;
	logic hit_route23;
	logic hit_ctrl;
	logic hit_status;
	logic mapped;
	logic setup;
	logic access;
	logic wr_lane0;
	logic [31:0] rd_word;
	logic [31:0] status_word;

	assign idx = paddr[7:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign hit_route01 = aligned & (idx == `SOR_IDX_ROUTE01);
	assign hit_route23 = aligned & (idx == `SOR_IDX_ROUTE23);
	assign hit_ctrl = aligned & (idx == `SOR_IDX_CTRL);
	assign hit_status = aligned & (idx == `SOR_IDX_STATUS);
	assign mapped = hit_route01 | hit_route23 | hit_ctrl | hit_status;
	assign setup = psel & ~penable;
	assign access = psel & penable;
	assign wr_lane0 = access & pwrite & pstrb[0] & mapped;
	assign pready = 1'b1;
	assign pslverr = access & ~mapped;
	assign prdata = prdata_reg;

	// Route selects per output channel
	sor_sel_t out_ch0_route_sel;
	sor_sel_t out_ch1_route_sel;
	sor_sel_t out_ch2_route_sel;
	sor_sel_t out_ch3_route_sel;
	sor_sel_t ch_sel [`SOR_N_OUT];
	wire sor_word_t ch_data;
	wire logic [`SOR_N_OUT-1:0] ch_rsvd;

	assign out_ch0_route_sel =
		serial_out_route_ch0_ch1_reg[`SOR_SEL_LO_POS +: `SOR_SEL_W];
	assign out_ch1_route_sel =
		serial_out_route_ch0_ch1_reg[`SOR_SEL_HI_POS +: `SOR_SEL_W];
	assign out_ch2_route_sel =
		serial_out_route_ch2_ch3_reg[`SOR_SEL_LO_POS +: `SOR_SEL_W];
	assign out_ch3_route_sel =
		serial_out_route_ch2_ch3_reg[`SOR_SEL_HI_POS +: `SOR_SEL_W];
	assign ch_sel[0] = out_ch0_route_sel;
	assign ch_sel[1] = out_ch1_route_sel;
	assign ch_sel[2] = out_ch2_route_sel;
	assign ch_sel[3] = out_ch3_route_sel;

	genvar g;
	generate
		for (g = 0; g < `SOR_N_OUT; g++) begin : gen_ch
			sor_mux u_mux (
				.sel(ch_sel[g]),
				.asrc_data(asrc_data),
				.sin_data(sin_data),
				.data(ch_data[g*`SOR_SAMPLE_W +: `SOR_SAMPLE_W]),
				.rsvd(ch_rsvd[g])
			);
		end
	endgenerate

	// Routed frames pass through the FIFO
	sor_stream_if wr_if ();
	sor_stream_if rd_if ();
	sor_lvl_t fifo_level;
	logic fifo_full;
	logic fifo_empty;
	logic route_en;
	logic pushed;

	assign route_en = ctrl_reg[`SOR_CTRL_EN_POS];
	assign wr_if.valid = src_valid & route_en;
	assign wr_if.data = ch_data;
	assign src_ready = ~route_en | wr_if.ready;
	assign pushed = wr_if.valid & wr_if.ready;
	assign rd_if.ready = out_ready;
	assign out_valid = rd_if.valid;
	assign out_data = rd_if.data;

	sor_fifo #(
		.W(`SOR_N_OUT*`SOR_SAMPLE_W),
		.DEPTH(`SOR_FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.wr(wr_if),
		.rd(rd_if),
		.level(fifo_level),
		.full(fifo_full),
		.empty(fifo_empty)
	);

	// Status and read mux
	assign status_word = {16'h0000, 4'h0, fifo_level, 2'h0, fifo_full, fifo_empty,
		rsvd_hit_reg};
	assign rd_word = hit_route01 ? {24'h000000, serial_out_route_ch0_ch1_reg} :
		hit_route23 ? {24'h000000, serial_out_route_ch2_ch3_reg} :
		hit_ctrl ? {24'h000000, ctrl_reg} :
		hit_status ? status_word : 32'h00000000;

	// Sticky reserved-code flags, set beats write-one-to-clear
	assign rsvd_hit_next = (wr_lane0 & hit_status) ?
		((rsvd_hit_reg & ~pwdata[`SOR_N_OUT-1:0]) | (ch_rsvd & {`SOR_N_OUT{pushed}})) :
		(rsvd_hit_reg | (ch_rsvd & {`SOR_N_OUT{pushed}}));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out_route_ch0_ch1_reg <= `SOR_RST_ROUTE01;
			serial_out_route_ch2_ch3_reg <= `SOR_RST_ROUTE23;
			ctrl_reg <= `SOR_RST_CTRL;
		end else if (wr_lane0) begin
			if (hit_route01) begin
				serial_out_route_ch0_ch1_reg <= pwdata[7:0];
			end
			if (hit_route23) begin
				serial_out_route_ch2_ch3_reg <= pwdata[7:0];
			end
			if (hit_ctrl) begin
				ctrl_reg <= {7'h00, pwdata[0]};
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rsvd_hit_reg <= '0;
		end else begin
			rsvd_hit_reg <= rsvd_hit_next;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata_reg <= 32'h00000000;
		end else if (setup & ~pwrite) begin
			prdata_reg <= rd_word;
		end
	end
endmodule

// ### test/serial_out_route_select_bench.sv
`timescale 1ns/100ps
module serial_out_route_select_bench import sor_pkg::*;;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic src_valid = 1'b0;
	logic src_ready;
	logic [95:0] asrc_data = 96'h0;
	logic [191:0] sin_data = 192'h0;
	logic out_valid;
	logic out_ready;
	sor_word_t out_data;
	logic [1:0] mode = 2'h0;
	int n_mismatch = 0;
	int tests_run = 0;
	sor_sel_t sl[4] = '{4'h4, 4'h5, 4'h6, 4'h7};
	sor_word_t exp_q[$];
	logic [31:0] r;
	logic e;
	always #5 clk = ~clk;
	sor_top i_sor_top (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hf), .prdata, .pready, .pslverr, .src_valid, .src_ready, .asrc_data,
		.sin_data, .out_valid, .out_ready, .out_data);
	sor_sink_model i_sor_sink_model (.clk, .rst_n, .mode, .out_valid, .out_data, .out_ready);
	function automatic sor_sample_t pick(sor_sel_t s, logic [95:0] a, logic [191:0] n);
		if (s[3])
			return n[s[2:0]*24 +: 24];
		return s[2] ? a[s[1:0]*24 +: 24] : 24'h0;
	endfunction
	task automatic chk(string n, logic [95:0] x, logic [95:0] g);
		tests_run++;
		if (g !== x) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", n, x, g);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic frame();
		logic [95:0] a;
		logic [191:0] n;
		sor_word_t w;
		@(posedge clk);
		a = {$urandom, $urandom, $urandom};
		n = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
		for (int k = 0; k < 4; k++)
			w[k*24 +: 24] = pick(sl[k], a, n);
		exp_q.push_back(w);
		asrc_data <= a;
		sin_data <= n;
		src_valid <= 1'b1;
		@(negedge clk);
		while (src_ready !== 1'b1)
			@(negedge clk);
		@(posedge clk);
		src_valid <= 1'b0;
	endtask
	task automatic drain();
		for (int i = 0; i < 900 && i_sor_sink_model.q.size() < exp_q.size(); i++)
			@(posedge clk);
		while (exp_q.size() > 0 && i_sor_sink_model.q.size() > 0)
			chk("word", exp_q.pop_front(), i_sor_sink_model.q.pop_front());
		chk("left", 96'h0, exp_q.size() + i_sor_sink_model.q.size());
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#100000;
		n_mismatch++;
		close_out();
	end
	initial begin
		void'($urandom(98));
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		apb(1'b0, 8'h4c, 32'h0);
		chk("route01", 96'h54, r);
		apb(1'b0, 8'h50, 32'h0);
		chk("route23", 96'h76, r);
		apb(1'b0, 8'h88, 32'h0);
		chk("unmapped", 96'h1_0000_0000, {e, r});
		apb(1'b0, 8'h80, 32'h0);
		chk("ctrl", 96'h1, r);
		apb(1'b1, 8'h80, 32'h0);
		apb(1'b0, 8'h80, 32'h0);
		chk("ctrl", 96'h0, r);
		@(posedge clk);
		src_valid <= 1'b1;
		@(negedge clk);
		chk("drop ready", 96'h1, src_ready);
		@(posedge clk);
		src_valid <= 1'b0;
		apb(1'b0, 8'h84, 32'h0);
		chk("status", 96'h010, r[11:0]);
		apb(1'b1, 8'h80, 32'h1);
		mode <= 2'h1;
		for (int i = 0; i < 12; i++) begin
			for (int k = 0; k < 4; k++)
				sl[k] = 4'h4 + 4'((i + 3 * k) % 12);
			apb(1'b1, 8'h4c, {sl[1], sl[0]});
			apb(1'b1, 8'h50, {sl[3], sl[2]});
			apb(1'b0, 8'h50, 32'h0);
			chk("route23", {sl[3], sl[2]}, r);
			repeat (3) frame();
		end
		drain();
		mode <= 2'h2;
		repeat (9) frame();
		@(negedge clk);
		chk("ready", 96'h0, src_ready);
		apb(1'b0, 8'h84, 32'h0);
		chk("status", 96'h820, r[11:0]);
		mode <= 2'h1;
		drain();
		close_out();
	end
endmodule

// ### test/sor_sink_model.sv
`timescale 1ns/100ps
module sor_sink_model import sor_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [1:0] mode,
	input wire logic out_valid,
	input wire sor_word_t out_data,
	output logic out_ready
);
	sor_word_t q[$];
	// Mode 0 takes all, 1 stalls at random, 2 stops
	always @(posedge clk) begin
		if (out_valid === 1'b1 && out_ready)
			q.push_back(out_data);
		out_ready <= rst_n && (mode == 2'h0 || (mode == 2'h1 && $urandom_range(1)));
	end
endmodule

// ### test/sor_top_checker.sv
`timescale 1ns/100ps
module sor_top_checker import sor_pkg::*; (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire sor_word_t out_data
);
	logic [7:0] s0_reg;
	logic [7:0] s1_reg;
	wire acc = psel & penable & pready;
	wire wr = acc & pwrite & pstrb[0];
	wire rd = acc & !pwrite;
	wire a0 = paddr == 8'h4c;
	wire a1 = paddr == 8'h50;
	// Shadow of the routing bytes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s0_reg <= 8'h54;
			s1_reg <= 8'h76;
		end else begin
			s0_reg <= wr & a0 ? pwdata[7:0] : s0_reg;
			s1_reg <= wr & a1 ? pwdata[7:0] : s1_reg;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence stall;
		out_valid && !out_ready;
	endsequence
	a_route01_value: assert property (rd && a0 |-> prdata[7:0] == s0_reg)
		else $error("route01 readback wrong");
	a_route23_value: assert property (rd && a1 |-> prdata[7:0] == s1_reg)
		else $error("route23 readback wrong");
	a_route_noerr: assert property (acc && (a0 || a1) |-> !pslverr)
		else $error("route register refused");
	a_word_hold: assert property (stall |=> out_valid && $stable(out_data))
		else $error("output word lost");
	a_upper_zero: assert property (rd && (a0 || a1) |-> prdata[31:8] == 24'h0)
		else $error("upper bits not zero");
endmodule
bind sor_top sor_top_checker i_sor_top_checker (.clk, .rst_n, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .out_valid, .out_ready, .out_data);
